// file: rtl/mdrm_pkg.sv
// Package of constants and carriers for the media defect recovery manager.
package mdrm_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [7:0] MDRM_CTRL_OFS = 8'h00;
    localparam logic [7:0] MDRM_RETRY_OFS = 8'h04;
    localparam logic [7:0] MDRM_TLIM_OFS = 8'h08;
    localparam logic [7:0] MDRM_STAT_OFS = 8'h0C;
    localparam logic [7:0] MDRM_LIST_OFS = 8'h10;
    // Control field positions and reset values.
    localparam int MDRM_CTRL_RARE_BIT = 0;
    localparam int MDRM_CTRL_WARE_BIT = 1;
    localparam int MDRM_CTRL_CONT_BIT = 2;
    localparam int MDRM_CTRL_PRES_BIT = 3;
    localparam logic [3:0] MDRM_CTRL_RST = 4'hB;
    // Retry count fields and their defaults.
    localparam int MDRM_RD_CNT_LSB = 0;
    localparam int MDRM_WR_CNT_LSB = 8;
    localparam logic [3:0] MDRM_RD_CNT_RST = 4'hC;
    localparam logic [2:0] MDRM_WR_CNT_RST = 3'h5;
    localparam logic [3:0] MDRM_RD_LVL_MAX = 4'hC;
    localparam logic [15:0] MDRM_TLIM_RST = 16'hFFFF;
    // Clock and time base.
    localparam int MDRM_CLK_NS = 5;
    localparam int MDRM_MS_NS = 1000000;
    localparam int MDRM_MS_CYC = MDRM_MS_NS / MDRM_CLK_NS;
    // Idle-time scan timing in milliseconds.
    localparam logic [9:0] MDRM_FIRST_IDLE_MS = 10'd5;
    localparam logic [9:0] MDRM_LATER_IDLE_MS = 10'd500;
    localparam logic [9:0] MDRM_BURST_MS = 10'd800;
    localparam logic [9:0] MDRM_SUSP_MS = 10'd100;
    localparam logic [9:0] MDRM_RESUME_MS = 10'd1;
    localparam int MDRM_POH_HOURS = 24;
    localparam int MDRM_POH_MS = MDRM_POH_HOURS * 3600 * 1000;
    // Per-block cumulative recovery caps in hundredths of a millisecond.
    localparam logic [17:0] MDRM_RD_CAP [13] = '{18'd10829, 18'd12495, 18'd42483,
        18'd45815, 18'd48314, 18'd59016, 18'd64492, 18'd71156, 18'd89854,
        18'd104949, 18'd111613, 18'd117444, 18'd231147};
    localparam logic [17:0] MDRM_WR_CAP [6] = '{18'd2394, 18'd3591, 18'd5586,
        18'd6783, 18'd11979, 18'd14772};
    localparam logic [6:0] MDRM_CENTI = 7'd100;
    // Recovery and scan state encodings.
    typedef enum logic [2:0] {R_IDLE = 3'b001, R_RUN = 3'b010, R_REAL = 3'b100} mdrm_rec_e;
    typedef enum logic [4:0] {S_WAIT = 5'b00001, S_SCAN = 5'b00010, S_SUSP = 5'b00100,
        S_DRAIN = 5'b01000, S_RESUME = 5'b10000} mdrm_scan_e;
    // Host command events.
    typedef struct packed {
        logic cmd_start;
        logic cmd_done;
        logic is_write;
        logic dest_verified;
        logic dar_hit;
    } mdrm_host_s;
    // Media recovery events.
    typedef struct packed {
        logic rec_start;
        logic rec_write;
        logic step_done;
        logic rec_ok;
        logic realloc_done;
        logic verify_fail;
    } mdrm_rec_s;
    // Background scan and idle verify events.
    typedef struct packed {
        logic pass_done;
        logic site_err;
        logic recov_busy;
        logic idle_verify_after_write_mismatch;
    } mdrm_scan_s;
endpackage

// file: rtl/mdrm_core.sv
// Defect and error recovery manager with idle-time scan control and APB registers.
//
// How it works
// - Twelve read levels, five write levels, stepwise.
// - Highest level capped by retry count.
// - Command recovery time bounded by limit register.
// - Per-block time bounded by retry count.
// - Read count maps to rising time cap.
// - Write count maps to rising time cap.
// - Reallocate only if enabled, not continuous, unexpired.
// - Reallocation time excluded from block and command timers.
// - Continuous flag blocks reallocation and error reports.
// - Limit hit unrecovered gives check condition.
// - Scan while idle, first after 5ms, later 500ms.
// - Scan bursts 800ms then 100ms pause.
// - Host command stops scan; scan recovery finishes.
// - Only first interrupting command delayed 1ms.
// - Scan sites logged or reallocated per enables.
// - Unverified-target writes become write-verify early.
// - Early-life scan starts at once when idle.
// - Early-life mode ends at the first completed scan pass or after 24 power-on hours.
// - Unreadable sites deferred; next write rewrites, verifies.
// - No enables: deferred write reports failing-location sense.
// - Idle reread of recent writes; mismatch rewrites.
// - Primary list fixed; grown list counts reallocations.
`timescale 1ns/1ps
module mdrm_core #(
    parameter int MS_CYC = mdrm_pkg::MDRM_MS_CYC,
    parameter int POH_LIMIT_MS = mdrm_pkg::MDRM_POH_MS,
    parameter logic [15:0] PLIST_CNT = 16'h0000
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_b,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_prdata,
    // Event inputs from firmware and channel logic.
    input wire mdrm_pkg::mdrm_host_s i_host,
    input wire mdrm_pkg::mdrm_rec_s i_rec,
    input wire mdrm_pkg::mdrm_scan_s i_scan,
    // Recovery outputs.
    output logic [3:0] o_level,
    output logic o_retry_go,
    output logic o_check_cond,
    output logic o_realloc_req,
    output logic o_dar_mark,
    output logic o_glist_add,
    // Write path outputs.
    output logic o_write_verify,
    output logic o_rewrite_req,
    output logic o_remap_req,
    output logic o_dar_sense,
    // Idle activity outputs.
    output logic o_scan_read,
    output logic o_scan_log,
    output logic o_host_hold,
    output logic o_idle_verify_after_write_en
);
    import mdrm_pkg::*;

    // Software settings.
    logic [3:0] ctrl_q;
    logic [3:0] rd_cnt_q;
    logic [2:0] wr_cnt_q;
    logic [15:0] tlim_q;
    logic [15:0] glist_q;
    // Time base and timers.
    logic [31:0] tick_cnt_q;
    logic ms_tick_q;
    logic [17:0] blk_ms_q;
    logic [15:0] cmd_ms_q;
    logic [9:0] phase_ms_q;
    logic [9:0] idle_ms_q;
    logic [31:0] poh_ms_q;
    // Recovery and scan state.
    mdrm_rec_e rec_q;
    mdrm_scan_e scan_q;
    logic rec_wr_q;
    logic [7:0] outst_q;
    logic first_done_q;
    logic pres_act_q;

    // Aliases of control bits.
    logic rare;
    logic ware;
    logic cont;
    assign rare = ctrl_q[MDRM_CTRL_RARE_BIT];
    assign ware = ctrl_q[MDRM_CTRL_WARE_BIT];
    assign cont = ctrl_q[MDRM_CTRL_CONT_BIT];

    // Decode of the APB access.
    logic setup;
    logic wr_acc;
    logic hit;
    assign setup = i_psel & ~i_penable;
    assign wr_acc = i_psel & i_penable & i_pwrite & o_pready;
    assign hit = (i_paddr == MDRM_CTRL_OFS) | (i_paddr == MDRM_RETRY_OFS) |
        (i_paddr == MDRM_TLIM_OFS) | (i_paddr == MDRM_STAT_OFS) |
        (i_paddr == MDRM_LIST_OFS);

    // Level cap and block time cap chosen from the retry settings.
    logic [3:0] rd_sel;
    logic [3:0] lvl_cap;
    logic [17:0] time_cap;
    logic [24:0] blk_centi;
    logic cmd_expired;
    logic rec_fail;
    logic rec_rlc_ok;
    assign rd_sel = (rd_cnt_q > MDRM_RD_LVL_MAX) ? MDRM_RD_LVL_MAX : rd_cnt_q;
    assign lvl_cap = rec_wr_q ? {1'b0, wr_cnt_q} : rd_sel;
    assign time_cap = rec_wr_q ? MDRM_WR_CAP[wr_cnt_q > 3'd5 ? 3'd5 : wr_cnt_q]
        : MDRM_RD_CAP[rd_sel];
    assign blk_centi = blk_ms_q * MDRM_CENTI;
    assign cmd_expired = cmd_ms_q >= tlim_q;
    assign rec_fail = (o_level > lvl_cap) | (blk_centi >= {7'd0, time_cap}) |
        cmd_expired;
    assign rec_rlc_ok = (rec_wr_q ? ware : rare) & ~cont & ~cmd_expired;

    // Idle means nothing outstanding from the host.
    logic idle;
    logic [9:0] idle_thr;
    assign idle = (outst_q == 8'h00);
    // Early life skips the delay so the first pass ends soon.
    assign idle_thr = pres_act_q ? 10'd0 : (first_done_q ? MDRM_LATER_IDLE_MS
        : MDRM_FIRST_IDLE_MS);

    // APB response; zero wait states, error on unmapped offsets.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end
        else
        begin
            // Ready rises for the access phase right after setup.
            o_pready <= setup;
            o_pslverr <= setup & ~hit;
            if (setup & ~i_pwrite)
            begin
                unique case (i_paddr)
                    MDRM_CTRL_OFS: o_prdata <= {28'h0000000, ctrl_q};
                    MDRM_RETRY_OFS: o_prdata <= {21'h000000, wr_cnt_q, 4'h0, rd_cnt_q};
                    MDRM_TLIM_OFS: o_prdata <= {16'h0000, tlim_q};
                    MDRM_STAT_OFS: o_prdata <= {cmd_ms_q, 11'h000, o_scan_read,
                        rec_q == R_RUN, first_done_q, pres_act_q, o_host_hold};
                    MDRM_LIST_OFS: o_prdata <= {PLIST_CNT, glist_q};
                    default: o_prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Writable settings; reads of status carry no side effects.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ctrl_q <= MDRM_CTRL_RST;
            rd_cnt_q <= MDRM_RD_CNT_RST;
            wr_cnt_q <= MDRM_WR_CNT_RST;
            tlim_q <= MDRM_TLIM_RST;
        end
        else if (wr_acc)
        begin
            if (i_paddr == MDRM_CTRL_OFS)
            begin
                ctrl_q <= i_pwdata[3:0];
            end
            if (i_paddr == MDRM_RETRY_OFS)
            begin
                rd_cnt_q <= i_pwdata[MDRM_RD_CNT_LSB +: 4];
                wr_cnt_q <= i_pwdata[MDRM_WR_CNT_LSB +: 3];
            end
            if (i_paddr == MDRM_TLIM_OFS)
            begin
                tlim_q <= i_pwdata[15:0];
            end
        end
    end

    // Millisecond time base from the 200 MHz clock.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tick_cnt_q <= 32'h0000_0000;
            ms_tick_q <= 1'b0;
        end
        else
        begin
            ms_tick_q <= (tick_cnt_q == 32'(MS_CYC - 1));
            tick_cnt_q <= (tick_cnt_q == 32'(MS_CYC - 1)) ? 32'h0000_0000
                : tick_cnt_q + 32'h0000_0001;
        end
    end

    // Count of outstanding host commands.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            outst_q <= 8'h00;
        end
        else if (i_host.cmd_start & ~i_host.cmd_done)
        begin
            outst_q <= outst_q + 8'h01;
        end
        else if (i_host.cmd_done & ~i_host.cmd_start & (outst_q != 8'h00))
        begin
            outst_q <= outst_q - 8'h01;
        end
    end

    // Block and command recovery timers; both freeze while reallocating.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            blk_ms_q <= 18'h00000;
            cmd_ms_q <= 16'h0000;
        end
        else
        begin
            // A new command restarts the whole-command budget.
            if (i_host.cmd_start)
            begin
                cmd_ms_q <= 16'h0000;
            end
            else if (ms_tick_q & (rec_q == R_RUN) & (cmd_ms_q != 16'hFFFF))
            begin
                cmd_ms_q <= cmd_ms_q + 16'h0001;
            end
            if (i_rec.rec_start & (rec_q == R_IDLE))
            begin
                blk_ms_q <= 18'h00000;
            end
            else if (ms_tick_q & (rec_q == R_RUN) & (blk_ms_q != 18'h3FFFF))
            begin
                blk_ms_q <= blk_ms_q + 18'h00001;
            end
        end
    end

    // Per-block recovery sequence.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rec_q <= R_IDLE;
            rec_wr_q <= 1'b0;
            o_level <= 4'h0;
            o_retry_go <= 1'b0;
            o_check_cond <= 1'b0;
            o_dar_mark <= 1'b0;
            o_glist_add <= 1'b0;
        end
        else
        begin
            o_check_cond <= 1'b0;
            o_dar_mark <= 1'b0;
            o_glist_add <= i_rec.realloc_done;
            unique case (rec_q)
                R_IDLE:
                begin
                    o_retry_go <= 1'b0;
                    if (i_rec.rec_start)
                    begin
                        rec_q <= R_RUN;
                        rec_wr_q <= i_rec.rec_write;
                        o_level <= 4'h0;
                        o_retry_go <= 1'b1;
                    end
                end
                R_RUN:
                begin
                    if (i_rec.rec_ok)
                    begin
                        // Recovered; move the block only when allowed.
                        o_retry_go <= 1'b0;
                        rec_q <= rec_rlc_ok ? R_REAL : R_IDLE;
                    end
                    else if (rec_fail)
                    begin
                        // Continuous mode hides the unrecovered result.
                        o_retry_go <= 1'b0;
                        o_check_cond <= ~cont;
                        o_dar_mark <= ~rec_wr_q;
                        rec_q <= R_IDLE;
                    end
                    else if (i_rec.step_done)
                    begin
                        o_level <= o_level + 4'h1;
                    end
                end
                R_REAL:
                begin
                    if (i_rec.realloc_done)
                    begin
                        rec_q <= R_IDLE;
                    end
                end
                default:
                begin
                    rec_q <= R_IDLE;
                end
            endcase
        end
    end

    // Grown defect count; the primary count is a fixed parameter.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            glist_q <= 16'h0000;
        end
        else if (i_rec.realloc_done & (glist_q != 16'hFFFF))
        begin
            glist_q <= glist_q + 16'h0001;
        end
    end

    // Reallocation and rewrite requests from all sources.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_realloc_req <= 1'b0;
            o_scan_log <= 1'b0;
            o_rewrite_req <= 1'b0;
            o_remap_req <= 1'b0;
            o_dar_sense <= 1'b0;
        end
        else
        begin
            o_realloc_req <= ((rec_q == R_RUN) & i_rec.rec_ok & rec_rlc_ok) |
                (i_scan.site_err & rare & ~cont);
            o_scan_log <= i_scan.site_err & ~(rare & ~cont);
            // A deferred site is rewritten in place, or flagged without enables.
            o_rewrite_req <= (i_host.cmd_start & i_host.is_write & i_host.dar_hit &
                (rare | ware)) | i_scan.idle_verify_after_write_mismatch;
            o_dar_sense <= i_host.cmd_start & i_host.is_write & i_host.dar_hit &
                ~rare & ~ware;
            o_remap_req <= i_rec.verify_fail;
        end
    end

    // Early-life write verify conversion and its power-on expiry.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            poh_ms_q <= 32'h0000_0000;
            pres_act_q <= 1'b1;
            o_write_verify <= 1'b0;
        end
        else
        begin
            if (ms_tick_q & (poh_ms_q != 32'(POH_LIMIT_MS)))
            begin
                poh_ms_q <= poh_ms_q + 32'h0000_0001;
            end
            // Once off it stays off: full write speed is the goal.
            if (~ctrl_q[MDRM_CTRL_PRES_BIT] | first_done_q |
                (poh_ms_q == 32'(POH_LIMIT_MS)))
            begin
                pres_act_q <= 1'b0;
            end
            o_write_verify <= i_host.cmd_start & i_host.is_write & pres_act_q &
                ~i_host.dest_verified;
        end
    end

    // Idle delay counter; every host command restarts it.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            idle_ms_q <= 10'h000;
        end
        else if (i_host.cmd_start | ~idle | (scan_q != S_WAIT))
        begin
            idle_ms_q <= 10'h000;
        end
        else if (ms_tick_q & (idle_ms_q != 10'h3FF))
        begin
            idle_ms_q <= idle_ms_q + 10'h001;
        end
    end

    // Background scan sequencer.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            scan_q <= S_WAIT;
            phase_ms_q <= 10'h000;
            first_done_q <= 1'b0;
        end
        else
        begin
            if (ms_tick_q)
            begin
                phase_ms_q <= phase_ms_q + 10'h001;
            end
            unique case (scan_q)
                S_WAIT:
                begin
                    if (idle & ~i_host.cmd_start & (idle_ms_q >= idle_thr))
                    begin
                        scan_q <= S_SCAN;
                        phase_ms_q <= 10'h000;
                    end
                end
                S_SCAN:
                begin
                    phase_ms_q <= ms_tick_q ? phase_ms_q + 10'h001 : phase_ms_q;
                    if (i_host.cmd_start)
                    begin
                        // Reads stop now; own recovery must drain first.
                        scan_q <= i_scan.recov_busy ? S_DRAIN : S_RESUME;
                        phase_ms_q <= 10'h000;
                    end
                    else if (i_scan.pass_done)
                    begin
                        first_done_q <= 1'b1;
                        scan_q <= S_WAIT;
                    end
                    else if (phase_ms_q >= MDRM_BURST_MS)
                    begin
                        scan_q <= S_SUSP;
                        phase_ms_q <= 10'h000;
                    end
                end
                S_SUSP:
                begin
                    if (i_host.cmd_start)
                    begin
                        scan_q <= S_WAIT;
                    end
                    else if (phase_ms_q >= MDRM_SUSP_MS)
                    begin
                        scan_q <= S_SCAN;
                        phase_ms_q <= 10'h000;
                    end
                end
                S_DRAIN:
                begin
                    phase_ms_q <= 10'h000;
                    if (~i_scan.recov_busy)
                    begin
                        scan_q <= S_RESUME;
                    end
                end
                S_RESUME:
                begin
                    // Only this one command waits; later ones find the scan parked.
                    if (phase_ms_q >= MDRM_RESUME_MS)
                    begin
                        scan_q <= S_WAIT;
                    end
                end
                default:
                begin
                    scan_q <= S_WAIT;
                end
            endcase
        end
    end

    // Idle activity flags seen by the media side.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_scan_read <= 1'b0;
            o_host_hold <= 1'b0;
            o_idle_verify_after_write_en <= 1'b0;
        end
        else
        begin
            o_scan_read <= (scan_q == S_SCAN) & ~i_host.cmd_start;
            o_host_hold <= (scan_q == S_DRAIN) | (scan_q == S_RESUME);
            // Reread of recent writes uses idle time the scan leaves free.
            o_idle_verify_after_write_en <= idle & ~i_host.cmd_start & (scan_q != S_SCAN);
        end
    end
endmodule

// file: sim/mdrm_core_sva.sv
// Checker for the recovery manager, bound to its top module.
`timescale 1ns/1ps
module mdrm_core_sva (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Watched ports.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire mdrm_pkg::mdrm_host_s i_host,
    input wire mdrm_pkg::mdrm_rec_s i_rec,
    input wire logic [3:0] o_level,
    input wire logic o_retry_go,
    input wire logic o_check_cond,
    input wire logic o_glist_add,
    input wire logic o_remap_req,
    input wire logic o_write_verify,
    input wire logic o_scan_read,
    input wire logic o_host_hold
);
    import mdrm_pkg::*;
    // One clock domain, so clocking and reset muting are shared.
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    // An APB setup is met by exactly one wait-free access cycle.
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_access;
        o_pready ##1 !o_pready;
    endsequence
    chk_apb_answer: assert property (s_setup |=> s_access)
        else $error("setup not answered in one cycle");
    chk_glist_grow: assert property (i_rec.realloc_done |=> o_glist_add)
        else $error("reallocation not recorded");
    chk_remap_fail: assert property (i_rec.verify_fail |=> o_remap_req)
        else $error("failed verify not remapped");
    chk_level_start: assert property ($rose(o_retry_go) |-> o_level == 4'h0 && $past(i_rec.rec_start))
        else $error("recovery did not start at level zero");
    chk_fail_ends: assert property (o_check_cond |-> $fell(o_retry_go))
        else $error("check condition while recovery runs");
    chk_scan_stop: assert property (i_host.cmd_start |=> !o_scan_read)
        else $error("scan kept reading after a command");
    chk_hold_quiet: assert property (o_host_hold |-> !o_scan_read)
        else $error("scan reads while host is held");
    chk_wv_cause: assert property (o_write_verify |-> $past(i_host.cmd_start && i_host.is_write))
        else $error("write verify without a write");
endmodule
bind mdrm_core mdrm_core_sva u_sva (.*);

// file: sim/mdrm_host_model.sv
// Host initiator model: issues commands as start and done events.
`timescale 1ns/1ps
module mdrm_host_model (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Bench request; kind is write, verified, deferred hit.
    input wire logic i_go,
    input wire logic [2:0] i_kind,
    // Command events toward the device.
    output mdrm_pkg::mdrm_host_s o_host
);
    import mdrm_pkg::*;
    logic [3:0] busy_q; // Cycles until the command completes.
    // Levels only mean something with cmd_start, so they wander otherwise.
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_host <= '0;
            busy_q <= 4'h0;
        end
        else
        begin
            o_host.cmd_start <= i_go;
            o_host.cmd_done <= (busy_q == 4'h1);
            busy_q <= i_go ? 4'h8 : busy_q - {3'h0, busy_q != 4'h0};
            o_host[2:0] <= i_go ? i_kind : ~o_host[2:0];
        end
    end
endmodule

// file: sim/tb_mdrm_core.sv
// Self-checking bench for the media defect recovery manager.
`timescale 1ns/1ps
module tb_mdrm_core;
    import mdrm_pkg::*;
    // Design ports share their names with these signals.
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic o_pready, o_pslverr, o_retry_go, o_check_cond, o_realloc_req, o_dar_mark, o_glist_add;
    logic o_write_verify, o_rewrite_req, o_remap_req, o_dar_sense, o_scan_read, o_scan_log, o_host_hold, o_idle_verify_after_write_en;
    logic [31:0] o_prdata, rd, v;
    logic [3:0] o_level;
    mdrm_host_s i_host;
    mdrm_rec_s i_rec = '0;
    mdrm_scan_s i_scan = '0; // Scan events stay quiet.
    logic go = 1'b0;
    logic [2:0] kind = 3'h0;
    logic err;
    logic [7:0] evt;
    logic [7:0] ad[5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
    logic [31:0] rv[5] = '{32'hB, 32'h50C, 32'hFFFF, 32'h0, 32'h0};
    int cnt[8];
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h0000BDDF;
    // The ms time base is cut to 10 cycles and power-on life to 50 ms.
    mdrm_core #(.MS_CYC(10), .POH_LIMIT_MS(50)) dut (.*);
    mdrm_host_model host_model (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_go(go), .i_kind(kind), .o_host(i_host));
    assign evt = {o_remap_req, o_dar_sense, o_rewrite_req, o_write_verify, o_glist_add, o_realloc_req, o_dar_mark,
        o_check_cond};
    always #2.5 i_clock = ~i_clock;
    // Pulses are counted on the falling edge, where they are settled.
    always @(negedge i_clock)
    begin
        cyc++;
        for (int k = 0; k < 8; k++)
            cnt[k] += evt[k];
        if (cyc == 20000)
        begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // One APB transfer; the request stands until pready is seen.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do @(posedge i_clock); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clock);
    endtask
    // Media event v and an optional host command of the given kind.
    task automatic pulse(input logic [5:0] v, input logic g, input logic [2:0] k);
        i_rec <= v;
        go <= g;
        kind <= k;
        @(posedge i_clock);
        i_rec <= '0;
        go <= 1'b0;
        repeat (2) @(posedge i_clock);
    endtask
    task automatic wait_cnt(input int i, input int n, input int cy);
        for (int c = 0; c < cy && cnt[i] < n; c++)
            @(posedge i_clock);
        check(cnt[i], n);
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (15) @(posedge i_clock);
        check(o_scan_read, 1'b1);
        pulse(6'h00, 1'b1, 3'h6);
        check(o_scan_read, 1'b0);
        @(posedge i_clock);
        check(o_host_hold, 1'b1);
        repeat (30) @(posedge i_clock);
        check(o_host_hold, 1'b0);
        pulse(6'h00, 1'b1, 3'h4);
        wait_cnt(4, 1, 10);
        pulse(6'h00, 1'b1, 3'h6);
        repeat (10) @(posedge i_clock);
        check(cnt[4], 1);
        pulse(6'h00, 1'b1, 3'h5);
        wait_cnt(5, 1, 10);
        for (int k = 0; k < 5; k++)
        begin
            apb(1'b0, ad[k], 32'h0);
            check(rd, rv[k]);
            check(err, k == 4);
        end
        apb(1'b1, MDRM_LIST_OFS, 32'hFFFFFFFF);
        apb(1'b0, MDRM_LIST_OFS, 32'h0);
        check(rd, 32'h0);
        repeat (4)
        begin
            v = rnd();
            v = {21'h0, v[10:8] % 3'h6, 4'h0, v[3:0] % 4'hD};
            apb(1'b1, MDRM_RETRY_OFS, v);
            apb(1'b0, MDRM_RETRY_OFS, 32'h0);
            check(rd, v);
        end
        apb(1'b1, MDRM_CTRL_OFS, 32'h0);
        apb(1'b1, MDRM_RETRY_OFS, 32'h500);
        cnt = '{default: 0};
        pulse(6'h20, 1'b0, 3'h0);
        pulse(6'h08, 1'b0, 3'h0);
        wait_cnt(0, 1, 10);
        check(cnt[1], 1);
        apb(1'b1, MDRM_RETRY_OFS, 32'h50C);
        apb(1'b1, MDRM_TLIM_OFS, 32'h3);
        cnt = '{default: 0};
        pulse(6'h20, 1'b1, 3'h0);
        repeat (15) @(posedge i_clock);
        check(cnt[0], 0);
        wait_cnt(0, 1, 40);
        apb(1'b1, MDRM_TLIM_OFS, 32'hFFFF);
        apb(1'b1, MDRM_RETRY_OFS, 32'h500);
        apb(1'b1, MDRM_CTRL_OFS, 32'h4);
        cnt = '{default: 0};
        pulse(6'h20, 1'b0, 3'h0);
        pulse(6'h08, 1'b0, 3'h0);
        repeat (10) @(posedge i_clock);
        check(cnt[0], 0);
        check(o_retry_go, 1'b0);
        apb(1'b1, MDRM_CTRL_OFS, 32'h1);
        pulse(6'h20, 1'b0, 3'h0);
        pulse(6'h04, 1'b0, 3'h0);
        wait_cnt(2, 1, 10);
        pulse(6'h02, 1'b0, 3'h0);
        wait_cnt(3, 1, 5);
        apb(1'b0, MDRM_LIST_OFS, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, MDRM_CTRL_OFS, 32'h0);
        pulse(6'h20, 1'b0, 3'h0);
        pulse(6'h04, 1'b0, 3'h0);
        pulse(6'h00, 1'b1, 3'h5);
        wait_cnt(6, 1, 10);
        check(cnt[2], 1);
        check(cnt[5], 0);
        pulse(6'h01, 1'b0, 3'h0);
        wait_cnt(7, 1, 5);
        print_verdict();
    end
endmodule
